// File: verilog/port_d_gpio_with_pin_mux.sv
// Port D: direction, latch and analog select registers, output priority mux,
// synchronised input path. Assumes pins are resolved outside from out/oe.

`timescale 1ns/10ps

module port_d_gpio_with_pin_mux #(
	parameter int  WIDTH         = port_d_pkg::WIDTH,
	parameter bit  LARGE_PACKAGE = 1'b1   // Port exists only on 40/44 pin parts
) (
	input  wire logic                    clk_sys,                // 40 MHz system clock
	input  wire logic                    reset_n,                // Power-on reset, active low
	input  wire port_d_pkg::reg_write_t  reg_wr,                 // Register write strobes
	input  wire logic                    pwm2b_pin_location_cfg, // 1: output B on pin 2
	input  wire port_d_pkg::periph_out_t periph_out,             // Peripheral output requests
	input  wire logic [WIDTH-1:0]        pin_in,                 // Pin levels from pads
	output logic [WIDTH-1:0]             pin_out,                // Pad output level
	output logic [WIDTH-1:0]             pin_oe,                 // Pad driver enable, high drives
	output logic [WIDTH-1:0]             pin_direction_reg,      // Direction readback
	output logic [WIDTH-1:0]             output_latch_reg,       // Latch readback
	output logic [WIDTH-1:0]             analog_select_reg,      // Analog select readback
	output logic [WIDTH-1:0]             port_read,              // Digital pin read value
	output port_d_pkg::periph_in_t       periph_in,              // Inputs to peripherals
	output logic [port_d_pkg::ANALOG_PINS-1:0] analog_enable     // Analog channels 20..25 live
);

	// =====================================================================
	// Registers
	logic [WIDTH-1:0] dir_r;        // Direction, one means input
	logic [WIDTH-1:0] latch_r;      // Output latch
	logic [WIDTH-1:0] ansel_r;      // Analog select, one means analog
	logic [WIDTH-1:0] sync1_r;      // First pad sample, may be metastable
	logic [WIDTH-1:0] sync2_r;      // Settled pad sample
	logic [WIDTH-1:0] drv_val_nxt;  // Level offered to each pad
	logic [WIDTH-1:0] dig_in;       // Settled pad level, analog pins masked
	logic             dir_take;     // Direction write lands
	logic             latch_take;   // Latch write lands
	logic             analog_take;  // Analog select write lands

	// Writes land only where the port is bonded out on this package
	assign dir_take    = reg_wr.dir_we && LARGE_PACKAGE;
	assign latch_take  = reg_wr.latch_we && LARGE_PACKAGE;
	assign analog_take = reg_wr.analog_we && LARGE_PACKAGE;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dir_r <= port_d_pkg::DIR_RESET;
		end else if (dir_take) begin
			dir_r <= reg_wr.wdata;
		end
	end

	// Read-modify-write software reads output_latch_reg, never the pad
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			latch_r <= port_d_pkg::LATCH_RESET;
		end else if (latch_take) begin
			latch_r <= reg_wr.wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ansel_r <= port_d_pkg::ANALOG_RESET;
		end else if (analog_take) begin
			ansel_r <= reg_wr.wdata;
		end
	end

	// =====================================================================
	// Priority helper shared by every muxed pin

	// Level of a pin with up to two peripheral sources ahead of the latch;
	// a pin with a single source ties the second enable low
	function automatic logic pick_level(
		input logic hi_en,     // Higher priority source enabled
		input logic hi_lvl,    // Its level
		input logic lo_en,     // Lower priority source enabled
		input logic lo_lvl,    // Its level
		input logic latch_lvl  // Latch bit, used when no source is enabled
	);
		logic level;
		level = latch_lvl;
		if (hi_en) begin
			level = hi_lvl;
		end else if (lo_en) begin
			level = lo_lvl;
		end
		return level;
	endfunction : pick_level

	// Pads are asynchronous to clk_sys: two flops before any reader
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// =====================================================================
	// Output priority, highest first; analog select plays no part here
	always_comb begin
		drv_val_nxt = latch_r;
		// Pin 0: SPI clock above I2C clock
		drv_val_nxt[port_d_pkg::PIN_SCK] = pick_level(
			periph_out.spi_clk_en,
			periph_out.spi_clk,
			periph_out.i2c_clk_en,
			periph_out.i2c_clk,
			latch_r[port_d_pkg::PIN_SCK]
		);
		// Pin 1: compare/PWM 4 above I2C data
		drv_val_nxt[port_d_pkg::PIN_SDA] = pick_level(
			periph_out.capture_compare_unit4_io_en,
			periph_out.capture_compare_unit4_io,
			periph_out.i2c_dat_en,
			periph_out.i2c_dat,
			latch_r[port_d_pkg::PIN_SDA]
		);
		// Pin 2: output B only at its default location
		drv_val_nxt[port_d_pkg::PIN_P2B] = pick_level(
			periph_out.pwm2b_en && pwm2b_pin_location_cfg,
			periph_out.pwm2b,
			1'b0,
			1'b0,
			latch_r[port_d_pkg::PIN_P2B]
		);
		// Pin 3
		drv_val_nxt[port_d_pkg::PIN_P2C] = pick_level(
			periph_out.pwm2c_en,
			periph_out.pwm2c,
			1'b0,
			1'b0,
			latch_r[port_d_pkg::PIN_P2C]
		);
		// Pin 4: enhanced PWM above SPI data out
		drv_val_nxt[port_d_pkg::PIN_P2D] = pick_level(
			periph_out.pwm2d_en,
			periph_out.pwm2d,
			periph_out.spi_dout_en,
			periph_out.spi_dout,
			latch_r[port_d_pkg::PIN_P2D]
		);
		// Pin 5
		drv_val_nxt[port_d_pkg::PIN_P1B] = pick_level(
			periph_out.pwm1b_en,
			periph_out.pwm1b,
			1'b0,
			1'b0,
			latch_r[port_d_pkg::PIN_P1B]
		);
	end

	// Peripherals drive only when direction is output, as the latch does
	assign pin_out = LARGE_PACKAGE ? drv_val_nxt : '0;
	assign pin_oe  = LARGE_PACKAGE ? ~dir_r : '0;

	// =====================================================================
	// Input side
	assign dig_in    = sync2_r & ~ansel_r;
	assign port_read = LARGE_PACKAGE ? dig_in : '0;
	// Analog channels need the pad released as well as analog selected
	assign analog_enable = LARGE_PACKAGE ? (ansel_r[port_d_pkg::ANALOG_PINS-1:0]
		& dir_r[port_d_pkg::ANALOG_PINS-1:0]) : '0;

	// Peripheral inputs follow the same digital gate; software must have set
	// the pin to input with analog cleared before relying on them
	always_comb begin
		periph_in.spi_clk    = port_read[port_d_pkg::PIN_SCK];
		periph_in.i2c_clk    = port_read[port_d_pkg::PIN_SCK];
		periph_in.capture_compare_unit4_io       = port_read[port_d_pkg::PIN_SDA];
		periph_in.spi_din    = port_read[port_d_pkg::PIN_SDA];
		periph_in.i2c_dat    = port_read[port_d_pkg::PIN_SDA];
		periph_in.client_sel = port_read[port_d_pkg::PIN_P2C];
	end

	// A port that is not bonded out reads back as zero
	assign pin_direction_reg = LARGE_PACKAGE ? dir_r : '0;
	assign output_latch_reg  = LARGE_PACKAGE ? latch_r : '0;
	assign analog_select_reg = LARGE_PACKAGE ? ansel_r : '0;

endmodule : port_d_gpio_with_pin_mux

// File: verilog/port_d_pkg.sv
// Constants and carrier types for the eight-pin port D with peripheral pin mux.
// Assumes a single system clock and an active-low asynchronous power-on reset.

package port_d_pkg;

	localparam int WIDTH = 8;

	// =====================================================================
	// Reset values
	localparam logic [7:0] DIR_RESET    = 8'hFF;
	localparam logic [7:0] LATCH_RESET  = 8'h00;
	localparam logic [7:0] ANALOG_RESET = 8'hFF;

	// =====================================================================
	// Pin positions
	localparam int PIN_SCK  = 0;
	localparam int PIN_SDA  = 1;
	localparam int PIN_P2B  = 2;
	localparam int PIN_P2C  = 3;
	localparam int PIN_P2D  = 4;
	localparam int PIN_P1B  = 5;

	// Analog channel numbers carried by pins 0..5
	localparam int ANALOG_FIRST_CH = 20;
	localparam int ANALOG_PINS     = 6;

	// =====================================================================
	// Register write strobes and data
	typedef struct packed {
		logic       dir_we;
		logic       latch_we;
		logic       analog_we;
		logic [7:0] wdata;
	} reg_write_t;

	// Peripheral outputs that want a pin: enable plus level
	typedef struct packed {
		logic spi_clk_en;   // serial2_spi_clock as output
		logic spi_clk;
		logic i2c_clk_en;   // serial2_i2c_clock driving low
		logic i2c_clk;
		logic capture_compare_unit4_io_en;      // capture_compare_unit4_io compare/PWM
		logic capture_compare_unit4_io;
		logic i2c_dat_en;
		logic i2c_dat;
		logic pwm2b_en;
		logic pwm2b;
		logic pwm2c_en;
		logic pwm2c;
		logic pwm2d_en;
		logic pwm2d;
		logic spi_dout_en;
		logic spi_dout;
		logic pwm1b_en;
		logic pwm1b;
	} periph_out_t;

	// Synchronised digital levels handed back to peripherals
	typedef struct packed {
		logic spi_clk;
		logic i2c_clk;
		logic capture_compare_unit4_io;
		logic spi_din;
		logic i2c_dat;
		logic client_sel;
	} periph_in_t;

endpackage : port_d_pkg

// File: tb/port_d_pin_model.sv
// Pad model for port D: resolves each pin from block drive and board level.
// Assumes ext carries the board level seen on released pins.
`timescale 1ns/10ps
module port_d_pin_model (
	input  wire logic [7:0] pin_out, // Block level
	input  wire logic [7:0] pin_oe,  // Block enable
	input  wire logic [7:0] ext,     // Board level
	output logic [7:0]      pin_in   // Pad level
);
	// ====================
	// Pad resolve
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : port_d_pin_model

// File: tb/port_d_gpio_with_pin_mux_asserts.sv
// Port relations of the port D mux.
// Assumes it is bound into port_d_gpio_with_pin_mux.
`timescale 1ns/10ps
module port_d_gpio_with_pin_mux_asserts #(parameter int WIDTH = 8) (
	input wire logic                    clk_sys,           // Clock
	input wire logic                    reset_n,           // Reset
	input wire port_d_pkg::reg_write_t  reg_wr,            // Writes
	input wire logic                    pwm2b_pin_location_cfg, // B place
	input wire port_d_pkg::periph_out_t periph_out,        // Drives
	input wire logic [WIDTH-1:0]        pin_in,            // Pads
	input wire logic [WIDTH-1:0]        pin_out,           // Level
	input wire logic [WIDTH-1:0]        pin_oe,            // Enable
	input wire logic [WIDTH-1:0]        pin_direction_reg, // Direction
	input wire logic [WIDTH-1:0]        output_latch_reg,  // Latch
	input wire logic [WIDTH-1:0]        analog_select_reg, // Analog
	input wire logic [WIDTH-1:0]        port_read,         // Read
	input wire logic [5:0]              analog_enable      // Channels
);
	// ====================
	// Properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	AST_OE: assert property (pin_oe == ~pin_direction_reg) else $error("oe");
	AST_DIR: assert property (reg_wr.dir_we |=>
		pin_direction_reg == $past(reg_wr.wdata)) else $error("dir");
	AST_LAT: assert property (reg_wr.latch_we |=>
		output_latch_reg == $past(reg_wr.wdata)) else $error("lat");
	AST_HOLD: assert property (!reg_wr.latch_we |=> $stable(output_latch_reg))
		else $error("hold");
	AST_LOUT: assert property (periph_out == '0 |-> pin_out == output_latch_reg)
		else $error("lout");
	AST_MASK: assert property ((port_read & analog_select_reg) == '0)
		else $error("mask");
	AST_SYNC: assert property (($stable(pin_in) && analog_select_reg == '0)[*3]
		|-> port_read == pin_in) else $error("sync");
	AST_P0: assert property (periph_out.spi_clk_en |->
		pin_out[0] == periph_out.spi_clk) else $error("p0");
	AST_P1: assert property (periph_out.capture_compare_unit4_io_en |->
		pin_out[1] == periph_out.capture_compare_unit4_io) else $error("p1");
	AST_P2: assert property (pwm2b_pin_location_cfg && periph_out.pwm2b_en |->
		pin_out[2] == periph_out.pwm2b) else $error("p2");
	AST_P4: assert property (periph_out.pwm2d_en |->
		pin_out[4] == periph_out.pwm2d) else $error("p4");
	AST_AEN: assert property (analog_enable ==
		(analog_select_reg[5:0] & pin_direction_reg[5:0])) else $error("aen");
	cover property (periph_out.spi_clk_en && periph_out.i2c_clk_en);
	cover property (reg_wr.dir_we && reg_wr.wdata == '0);
	cover property (port_read != '0);
endmodule : port_d_gpio_with_pin_mux_asserts
bind port_d_gpio_with_pin_mux port_d_gpio_with_pin_mux_asserts #(.WIDTH(WIDTH)) i_asserts (
	.clk_sys, .reset_n, .reg_wr, .pwm2b_pin_location_cfg, .periph_out, .pin_in, .pin_out,
	.pin_oe, .pin_direction_reg, .output_latch_reg, .analog_select_reg, .port_read,
	.analog_enable);

// File: tb/port_d_gpio_with_pin_mux_test.sv
// Self-checking bench for the port D mux.
// Assumes the pad model closes the pin loop.
`timescale 1ns/10ps
module port_d_gpio_with_pin_mux_test;
	typedef struct packed {
		logic [7:0] dir; logic [7:0] lat; logic cfg; logic [17:0] po; logic [7:0] exp;
	} row_t;
	logic clk_sys = 0, reset_n = 0, cfg = 1;
	port_d_pkg::reg_write_t  reg_wr = '0;
	port_d_pkg::periph_out_t po = '0;
	port_d_pkg::periph_in_t  pi;
	logic [7:0] ext = 8'h00, pin_in, pin_out, pin_oe, dir, lat, ana, rd;
	logic [5:0] aen;
	int fail_count = 0, tests_run = 0;
	row_t rows [10] = '{'{8'h00, 8'hA5, 1, 18'h00000, 8'hA5}, '{8'h00, 8'h00, 1, 18'h38000, 8'h01},
		'{8'h00, 8'hFF, 1, 18'h08000, 8'hFE}, '{8'h00, 8'h02, 1, 18'h02C00, 8'h00},
		'{8'h00, 8'h00, 1, 18'h00C00, 8'h02}, '{8'h00, 8'h00, 1, 18'h003C3, 8'h2C},
		'{8'h00, 8'h00, 0, 18'h00300, 8'h00}, '{8'h00, 8'h10, 1, 18'h0002C, 8'h00},
		'{8'h00, 8'h00, 1, 18'h0000C, 8'h10}, '{8'hF0, 8'hFF, 1, 18'h00000, 8'hFF}};
	port_d_gpio_with_pin_mux i_port_d_gpio_with_pin_mux (.clk_sys(clk_sys), .reset_n(reset_n),
		.reg_wr(reg_wr), .pwm2b_pin_location_cfg(cfg), .periph_out(po), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_direction_reg(dir), .output_latch_reg(lat),
		.analog_select_reg(ana), .port_read(rd), .periph_in(pi), .analog_enable(aen));
	port_d_pin_model i_port_d_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
		.pin_in(pin_in));
	// ====================
	// Tasks
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [2:0] we, input logic [7:0] d);
		@(posedge clk_sys);
		#1 reg_wr = {we, d};
		@(posedge clk_sys);
		#1 reg_wr = '0;
	endtask : wr
	task automatic test_done;
		if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	// ====================
	// Sequence
	initial forever #12.5 clk_sys = ~clk_sys;
	initial begin
		repeat (16) @(posedge clk_sys);
		#1 chk("dir", dir, 8'hFF);
		chk("lat", lat, 8'h00);
		chk("ana", ana, 8'hFF);
		chk("oe", pin_oe, 8'h00);
		chk("aen", {2'b00, aen}, 8'h3F);
		reset_n = 1;
		foreach (rows[i]) begin
			wr(3'b100, rows[i].dir);
			po = rows[i].po;
			cfg = rows[i].cfg;
			wr(3'b010, rows[i].lat);
			chk("oe", pin_oe, ~rows[i].dir);
			chk("lat", lat, rows[i].lat);
			chk("out", pin_out, rows[i].exp);
		end
		po = '0;
		wr(3'b100, 8'hFF);
		wr(3'b001, 8'h00);
		ext = 8'h96;
		repeat (3) @(posedge clk_sys);
		#1 chk("rd", rd, 8'h96);
		chk("pin", {2'b00, pi}, 8'h0E);
		wr(3'b001, 8'h0F);
		chk("rd", rd, 8'h90);
		chk("aen", {2'b00, aen}, 8'h0F);
		wr(3'b100, 8'h00);
		wr(3'b010, 8'h3C);
		repeat (3) @(posedge clk_sys);
		#1 chk("rd", rd, 8'h30);
		test_done();
	end
endmodule : port_d_gpio_with_pin_mux_test
